// File: bench/ntlc_ctrl_tb.sv
// self-checking bench for the nt1 test, loopback and termination control
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module ntlc_ctrl_tb
  import ntlc_pkg::*;
;
  logic          clk;
  logic          rstn;
  ntlc_pins_t    pins;
  ntlc_pins_t    p;
  logic          h1, usync, uoa, act, eoc2, eb1, eb2;
  logic          frame_en, u_pulse, pn, dc, act_en, g3, fh1, led, ntm;
  logic          ps1, ps2, adapt, relay, unable;
  ntlc_bd_t      u_rx, st_rx, st_tx, u_tx, ur, sr;
  ntlc_st_info_t st_info;
  ntlc_u_test_t  u_test;
  int            bad_count, comparisons, n, k;
  ntlc_u_test_t  ue [6] = '{NTLC_U_PULSE3, NTLC_U_PN, NTLC_U_PULSE0, NTLC_U_DATA, NTLC_U_DATA,
                            NTLC_U_DATA};
  ntlc_st_info_t se [6] = '{NTLC_ST_DATA, NTLC_ST_DATA, NTLC_ST_DATA, NTLC_ST_INFO2,
                            NTLC_ST_INFO4, NTLC_ST_DATA};
  localparam ntlc_bd_t ONES = '{b1: IDLE_BYTE, b2: IDLE_BYTE, d: IDLE_D};

  ntlc_far_model ntlc_far_model_i (.clk(clk), .rstn(rstn), .frame_en(frame_en),
    .u_rx(u_rx), .st_rx(st_rx));

  ntlc_ctrl ntlc_ctrl_i (.clk(clk), .rstn(rstn), .pins(pins), .h_state_is_h1(h1),
    .u_synced(usync), .rx_uoa_bit(uoa), .rx_act_bit(act), .eoc_loop2_req(eoc2),
    .eoc_b1_req(eb1), .eoc_b2_req(eb2), .u_rx(u_rx), .st_rx(st_rx), .frame_en(frame_en),
    .st_tx(st_tx), .u_tx(u_tx), .st_info(st_info), .u_test(u_test), .u_pulse(u_pulse),
    .u_pn_bit(pn), .dc_term_switch(dc), .st_act_enable(act_en), .force_g3(g3),
    .force_h1(fh1), .test_indicator(led), .tx_ntm_bit(ntm), .tx_ps1(ps1), .tx_ps2(ps2),
    .adaptive_timing(adapt), .loop2_relay_ctl(relay), .eoc_unable(unable));

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  // one place prints the verdict and stops the run
  task automatic complete_run();
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // quiet board: no loops, detection on, power status not equal to the fixed pair
  function automatic ntlc_pins_t base();
    ntlc_pins_t q;
    q = '1;
    q.test_sel = TSEL_LOOP2;
    q.metallic_test_en = 1'h0;
    q.line_full_reset_in = 1'h0;
    q.power_status_a = 1'h0;
    return q;
  endfunction

  // pins cross a synchroniser, so give them margin before looking
  task automatic apply(input ntlc_pins_t v);
    @(posedge clk);
    pins <= v;
    repeat (8) @(posedge clk);
    #1;
  endtask

  // same-clock levels: h1, usync, uoa, act, eoc2, eb1, eb2
  task automatic lvl(input logic [6:0] v);
    @(posedge clk);
    {h1, usync, uoa, act, eoc2, eb1, eb2} <= v;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // bounded wait for a frame strobe; keep the octets the design takes
  task automatic grab();
    n = 0;
    while (frame_en !== 1'h1 && n < 64)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (frame_en !== 1'h1)
    begin
      bad_count++;
      complete_run();
    end
    ur = u_rx;
    sr = st_rx;
    @(posedge clk);
    #1;
  endtask

  // bounded wait for the next test pulse, looked at just after each edge
  task automatic wait_pulse();
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (u_pulse !== 1'h1 && n < 30000);
    if (u_pulse !== 1'h1)
    begin
      bad_count++;
      complete_run();
    end
  endtask

  // free-running 250 mhz clock
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    bad_count = 0;
    comparisons = 0;
    rstn = 1'h0;
    pins = base();
    {h1, usync, uoa, act, eoc2, eb1, eb2} = 7'h00;
    repeat (5) @(posedge clk);
    #1;
    `CHK(dc, 1'h0)
    `CHK({ps1, ps2, adapt, ntm}, 4'hb)
    `CHK(st_tx, ONES)
    @(posedge clk);
    rstn <= 1'h1;
    apply(base());
    lvl(7'h38);
    `CHK({dc, act_en, g3, fh1, led, ntm}, 6'h31)
    `CHK({ps1, ps2, adapt, relay, unable}, 5'h0c)
    `CHK({st_info, u_test}, {NTLC_ST_DATA, NTLC_U_DATA})
    grab();
    `CHK(st_tx, ur)
    `CHK(u_tx, sr)
    lvl(7'h68);
    `CHK({dc, act_en}, 2'h0)
    p = base();
    p.uoa_sel = 1'h0;
    p.st_only_activation_n = 1'h0;
    p.fixed_timing_n = 1'h0;
    p.metallic_test_en = 1'h1;
    p.line_full_reset_in = 1'h1;
    p.power_loss_detect_en = 1'h0;
    apply(p);
    `CHK({act_en, g3, adapt, fh1, ps1, ps2}, 6'h36)
    p.metallic_test_en = 1'h0;
    p.st_only_activation_n = 1'h1;
    apply(p);
    `CHK({g3, fh1}, 2'h0)
    // local loop 2, nontransparent; manual loop c pins stay high
    p = base();
    p.local_test_n = 1'h0;
    p.loop_transparent_sel = 1'h0;
    apply(p);
    lvl(7'h38);
    `CHK({led, ntm, ps1, ps2}, 4'ha)
    grab();
    `CHK(st_info, NTLC_ST_INFO0)
    `CHK(st_tx, ONES)
    `CHK(u_tx, ur)
    lvl(7'h18);
    `CHK(ntm, 1'h1)
    p.test_sel = TSEL_LOOPC;
    apply(p);
    grab();
    `CHK(st_tx, ntlc_bd_t'({sr.b1, sr.b2, ur.d}))
    `CHK(u_tx, ntlc_bd_t'({IDLE_BYTE, IDLE_BYTE, sr.d}))
    // every remaining code; the info codes run with the u side down
    for (k = 2; k < 8; k++)
    begin
      p.test_sel = 3'(k);
      apply(p);
      `CHK(u_test, ue[k-2])
      `CHK(st_info, se[k-2])
    end
    p.test_sel = TSEL_PULSE3;
    apply(p);
    wait_pulse();
    wait_pulse();
    `CHK(n, PULSE3_CYCLES)
    // a full 127-bit m-sequence carries 64 ones, whatever its phase
    p.test_sel = TSEL_PN;
    apply(p);
    k = 0;
    repeat (127)
    begin
      grab();
      k += pn;
    end
    `CHK(k, 64)
    lvl(7'h38);
    p = base();
    p.b1_loopc_n = 1'h0;
    p.loop_transparent_sel = 1'h0;
    apply(p);
    grab();
    `CHK(st_tx, ntlc_bd_t'({sr.b1, ur.b2, ur.d}))
    `CHK(u_tx, ntlc_bd_t'({IDLE_BYTE, sr.b2, sr.d}))
    p = base();
    p.b2_loopc_n = 1'h0;
    apply(p);
    grab();
    `CHK(st_tx, ntlc_bd_t'({ur.b1, sr.b2, ur.d}))
    `CHK(u_tx, sr)
    lvl(7'h3c);
    `CHK(unable, 1'h1)
    grab();
    `CHK(st_info, NTLC_ST_DATA)
    `CHK(st_tx, ntlc_bd_t'({ur.b1, sr.b2, ur.d}))
    apply(base());
    grab();
    `CHK(unable, 1'h0)
    `CHK(st_tx, ur)
    `CHK(u_tx, ur)
    lvl(7'h34);
    `CHK(st_info, NTLC_ST_INFO2)
    p = base();
    p.internal_rx_sel = 1'h0;
    apply(p);
    lvl(7'h3c);
    `CHK(relay, 1'h1)
    grab();
    `CHK(u_tx, sr)
    lvl(7'h2c);
    `CHK(relay, 1'h0)
    grab();
    `CHK(st_info, NTLC_ST_INFO0)
    `CHK(u_tx, ur)
    // eoc b1 partial loop, nontransparent, no loop c pending
    p.loop_transparent_sel = 1'h0;
    apply(p);
    lvl(7'h3a);
    grab();
    `CHK(st_tx, ntlc_bd_t'({IDLE_BYTE, ur.b2, ur.d}))
    `CHK(u_tx, ntlc_bd_t'({ur.b1, sr.b2, sr.d}))
    complete_run();
  end
endmodule

// File: bench/ntlc_far_model.sv
// far-side model: line termination and terminals feeding framed 2b+d data
`timescale 1ns/100ps
module ntlc_far_model
  import ntlc_pkg::*;
#(
  parameter int unsigned GAP = 12      // cycles between frame strobes
)(
  input  wire logic clk,               // system clock
  input  wire logic rstn,              // async reset, active low
  output logic      frame_en,          // one-cycle frame strobe
  output ntlc_bd_t  u_rx,              // octets from the line termination
  output ntlc_bd_t  st_rx              // octets from the terminals
);
  logic [7:0] gap_q;
  logic [7:0] seq_q;

  // frame pacing; the octets change every frame so a stale route shows
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gap_q    <= 8'h00;
      seq_q    <= 8'h00;
      frame_en <= 1'h0;
    end
    else
    begin
      frame_en <= (gap_q == 8'(GAP - 1));
      gap_q    <= (gap_q == 8'(GAP - 1)) ? 8'h00 : gap_q + 8'h01;
      if (frame_en)
        seq_q <= seq_q + 8'h01;
    end
  end

  // the two sides never carry the same pattern, so a swap is caught
  assign u_rx  = '{b1: seq_q ^ 8'h5a, b2: seq_q ^ 8'h3c, d: seq_q[1:0]};
  assign st_rx = '{b1: seq_q ^ 8'h96, b2: seq_q ^ 8'hc3, d: ~seq_q[1:0]};
endmodule

// File: common/ntlc_pkg.sv
// package: shared types and constants for the nt1 test/loopback control block
package ntlc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 4000;
  localparam int unsigned PULSE3_PERIOD_US = 100;   // 0.1 ms
  localparam int unsigned PULSE0_PERIOD_US = 1000;  // 1 ms
  localparam int unsigned PULSE3_CYCLES =
    (PULSE3_PERIOD_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned PULSE0_CYCLES =
    (PULSE0_PERIOD_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned PULSE_CNT_W = 18;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [2:0] TSEL_LOOP2   = 3'h0;
  localparam logic [2:0] TSEL_LOOPC   = 3'h1;
  localparam logic [2:0] TSEL_PULSE3  = 3'h2;
  localparam logic [2:0] TSEL_PN      = 3'h3;
  localparam logic [2:0] TSEL_PULSE0  = 3'h4;
  localparam logic [2:0] TSEL_INFO2   = 3'h5;
  localparam logic [2:0] TSEL_INFO4   = 3'h6;
  localparam logic [2:0] TSEL_CHIP    = 3'h7;
  localparam logic [7:0] IDLE_BYTE    = 8'hff;
  localparam logic [1:0] IDLE_D       = 2'h3;
  localparam logic [6:0] PN_SEED      = 7'h7f;
  localparam int unsigned SYNC_W      = 11;

  // st-side line signal selection
  typedef enum logic [3:0] {
    NTLC_ST_DATA  = 4'b0001,
    NTLC_ST_INFO0 = 4'b0010,
    NTLC_ST_INFO2 = 4'b0100,
    NTLC_ST_INFO4 = 4'b1000
  } ntlc_st_info_t;

  // u-side test signal selection
  typedef enum logic [3:0] {
    NTLC_U_DATA   = 4'b0001,
    NTLC_U_PULSE3 = 4'b0010,
    NTLC_U_PN     = 4'b0100,
    NTLC_U_PULSE0 = 4'b1000
  } ntlc_u_test_t;

  // one 2b+d octet group
  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [1:0] d;
  } ntlc_bd_t;

  // static control pins as a group
  typedef struct packed {
    logic       uoa_sel;
    logic       st_only_activation_n;
    logic       local_test_n;
    logic [2:0] test_sel;
    logic       loop_transparent_sel;
    logic       metallic_test_en;
    logic       line_full_reset_in;
    logic       b1_loopc_n;
    logic       b2_loopc_n;
    logic       fixed_timing_n;
    logic       power_loss_detect_en;
    logic       power_status_a;
    logic       power_status_b;
    logic       internal_rx_sel;
  } ntlc_pins_t;

endpackage

// File: src/ntlc_ctrl.sv
// top: nt1 test, loopback and termination control
`timescale 1ns/100ps
module ntlc_ctrl
  import ntlc_pkg::*;
(
  input  wire logic          clk,                 // 250 mhz system clock
  input  wire logic          rstn,                // async reset, active low
  input  wire ntlc_pins_t    pins,                // static control pins (async)
  input  wire logic          h_state_is_h1,       // h machine in full-reset state
  input  wire logic          u_synced,            // u interface synchronised
  input  wire logic          rx_uoa_bit,          // received m4 uoa bit
  input  wire logic          rx_act_bit,          // received m4 act bit
  input  wire logic          eoc_loop2_req,       // eoc 2b+d loop 2 active request
  input  wire logic          eoc_b1_req,          // eoc b1 loop 2 request
  input  wire logic          eoc_b2_req,          // eoc b2 loop 2 request
  input  wire ntlc_bd_t      u_rx,                // data received from u
  input  wire ntlc_bd_t      st_rx,               // data received from s/t
  input  wire logic          frame_en,            // one-cycle frame strobe
  output ntlc_bd_t           st_tx,               // data sent to s/t
  output ntlc_bd_t           u_tx,                // data sent to u
  output ntlc_st_info_t      st_info,             // s/t line signal choice
  output ntlc_u_test_t       u_test,              // u line test signal choice
  output logic               u_pulse,             // single test pulse strobe
  output logic               u_pn_bit,            // pn test bit
  output logic               dc_term_switch,      // dc termination on
  output logic               st_act_enable,       // s/t activation allowed
  output logic               force_g3,            // force g machine to g3
  output logic               force_h1,            // force h machine to h1
  output logic               test_indicator,      // local test lamp
  output logic               tx_ntm_bit,          // m4 ntm bit to lt
  output logic               tx_ps1,              // m channel ps1
  output logic               tx_ps2,              // m channel ps2
  output logic               adaptive_timing,     // s/t adaptive sampling
  output logic               loop2_relay_ctl,     // external loop 2 relay
  output logic               eoc_unable           // unable-to-comply echo
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  ntlc_pins_t p;

  ntlc_sync #(.W($bits(ntlc_pins_t))) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  (pins),
    .dout (p)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic local_test;
  logic lt_loop2;
  logic lt_loopc;
  logic man_b1;
  logic man_b2;
  logic loopc_b1;
  logic loopc_b2;
  logic any_loopc;
  logic ext_mode;
  logic full_loop2;
  logic ext_loop2;
  logic nontransp;
  logic psd_eff;

  assign local_test = !p.local_test_n;
  assign lt_loop2   = local_test && (p.test_sel == TSEL_LOOP2);
  assign lt_loopc   = local_test && (p.test_sel == TSEL_LOOPC);
  assign man_b1     = !p.b1_loopc_n;
  assign man_b2     = !p.b2_loopc_n;
  assign loopc_b1   = man_b1 || lt_loopc;
  assign loopc_b2   = man_b2 || lt_loopc;
  assign any_loopc  = loopc_b1 || loopc_b2;
  assign ext_mode   = !p.internal_rx_sel;
  // manual loop c keeps priority over eoc loop 2
  assign full_loop2 = (lt_loop2 || (eoc_loop2_req && !any_loopc));
  assign ext_loop2  = full_loop2 && ext_mode && rx_uoa_bit;
  assign nontransp  = !p.loop_transparent_sel;
  assign psd_eff    = p.power_loss_detect_en && !local_test;

  // ----------------------------------------------------------------
  // static control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dc_term_switch  <= 1'b0;
      st_act_enable   <= 1'b0;
      force_g3        <= 1'b0;
      force_h1        <= 1'b0;
      test_indicator  <= 1'b0;
      tx_ntm_bit      <= 1'b1;
      tx_ps1          <= 1'b1;
      tx_ps2          <= 1'b0;
      adaptive_timing <= 1'b1;
      loop2_relay_ctl <= 1'b0;
      eoc_unable      <= 1'b0;
    end
    else
    begin
      dc_term_switch  <= !h_state_is_h1;
      st_act_enable   <= p.uoa_sel ? rx_uoa_bit : 1'b1;
      force_g3        <= !p.st_only_activation_n;
      force_h1        <= p.metallic_test_en && p.line_full_reset_in;
      test_indicator  <= local_test;
      tx_ntm_bit      <= !(local_test && u_synced);
      tx_ps1          <= psd_eff ? p.power_status_a : 1'b1;
      tx_ps2          <= psd_eff ? p.power_status_b : 1'b0;
      adaptive_timing <= p.fixed_timing_n;
      loop2_relay_ctl <= ext_loop2;
      // eoc request refused while a manual or local loop c holds
      eoc_unable      <= any_loopc && (eoc_loop2_req || eoc_b1_req || eoc_b2_req);
    end
  end

  // ----------------------------------------------------------------
  // s/t line signal and u test signal selection
  // ----------------------------------------------------------------
  ntlc_st_info_t st_info_d;
  ntlc_u_test_t  u_test_d;

  always_comb
  begin
    st_info_d = NTLC_ST_DATA;
    u_test_d  = NTLC_U_DATA;
    if (local_test && p.test_sel == TSEL_INFO2)
      st_info_d = NTLC_ST_INFO2;
    else if (local_test && p.test_sel == TSEL_INFO4)
      st_info_d = NTLC_ST_INFO4;
    else if (full_loop2 && (nontransp || (ext_mode && !rx_uoa_bit)))
      st_info_d = NTLC_ST_INFO0;
    else if (full_loop2 && !rx_act_bit)
      st_info_d = NTLC_ST_INFO2;
    if (local_test && p.test_sel == TSEL_PULSE3)
      u_test_d = NTLC_U_PULSE3;
    else if (local_test && p.test_sel == TSEL_PN)
      u_test_d = NTLC_U_PN;
    else if (local_test && p.test_sel == TSEL_PULSE0)
      u_test_d = NTLC_U_PULSE0;
  end

  // registered so that the outputs come straight from flops
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_info <= NTLC_ST_DATA;
      u_test  <= NTLC_U_DATA;
    end
    else
    begin
      st_info <= st_info_d;
      u_test  <= u_test_d;
    end
  end

  // ----------------------------------------------------------------
  // test pulse period counter; held cleared while neither pulse mode is selected
  // ----------------------------------------------------------------
  logic [PULSE_CNT_W-1:0] pcnt_q;
  logic [PULSE_CNT_W-1:0] plimit;

  assign plimit = (u_test == NTLC_U_PULSE3) ? PULSE_CNT_W'(PULSE3_CYCLES - 1)
                                            : PULSE_CNT_W'(PULSE0_CYCLES - 1);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pcnt_q  <= '0;
      u_pulse <= 1'b0;
    end
    else if (u_test != NTLC_U_PULSE3 && u_test != NTLC_U_PULSE0)
    begin
      pcnt_q  <= '0;
      u_pulse <= 1'b0;
    end
    else
    begin
      u_pulse <= (pcnt_q == plimit);
      pcnt_q  <= (pcnt_q == plimit) ? '0 : pcnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pn pattern, x^7+x^6+1, one bit per frame strobe
  // ----------------------------------------------------------------
  logic [6:0] pn_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pn_q     <= PN_SEED;
      u_pn_bit <= 1'b0;
    end
    else if (u_test == NTLC_U_PN && frame_en)
    begin
      pn_q     <= {pn_q[5:0], pn_q[6] ^ pn_q[5]};
      u_pn_bit <= pn_q[6];
    end
  end

  // ----------------------------------------------------------------
  // data routing: loop c toward s/t, loop 2 toward u
  // ----------------------------------------------------------------
  logic eoc_b1_eff;
  logic eoc_b2_eff;
  logic int_loop2;

  // eoc partial loops refused while any loop c holds
  assign eoc_b1_eff = eoc_b1_req && !any_loopc;
  assign eoc_b2_eff = eoc_b2_req && !any_loopc;
  // external loop point leaves u data untouched inside the chip
  assign int_loop2  = full_loop2 && !ext_loop2;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_tx <= '{b1: IDLE_BYTE, b2: IDLE_BYTE, d: IDLE_D};
      u_tx  <= '{b1: IDLE_BYTE, b2: IDLE_BYTE, d: IDLE_D};
    end
    else if (frame_en)
    begin
      // s/t side: loop c returns s/t data, d stays transparent
      st_tx.b1 <= loopc_b1 ? st_rx.b1 : u_rx.b1;
      st_tx.b2 <= loopc_b2 ? st_rx.b2 : u_rx.b2;
      st_tx.d  <= u_rx.d;
      if (full_loop2 && nontransp)
        st_tx <= '{b1: IDLE_BYTE, b2: IDLE_BYTE, d: IDLE_D};
      else
      begin
        if (eoc_b1_eff && nontransp)
          st_tx.b1 <= IDLE_BYTE;
        if (eoc_b2_eff && nontransp)
          st_tx.b2 <= IDLE_BYTE;
      end
      // u side: loop 2 returns u data
      u_tx.b1 <= (int_loop2 || eoc_b1_eff) ? u_rx.b1 : st_rx.b1;
      u_tx.b2 <= (int_loop2 || eoc_b2_eff) ? u_rx.b2 : st_rx.b2;
      u_tx.d  <= int_loop2 ? u_rx.d : st_rx.d;
      if (loopc_b1 && nontransp)
        u_tx.b1 <= IDLE_BYTE;
      if (loopc_b2 && nontransp)
        u_tx.b2 <= IDLE_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // checks wake one edge after reset lifts: the release edge itself
  // still loads reset values, so a check started there would misfire
  logic chk_on_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      chk_on_q <= 1'b0;
    else
      chk_on_q <= 1'b1;
  end

  sequence s_loopc_held;
    any_loopc && eoc_loop2_req;
  endsequence

  dc_term_off_a: assert property (@(posedge clk) disable iff (!chk_on_q)
    h_state_is_h1 |=> !dc_term_switch)
    else $error("termination switch on during h1");

  uoa_gate_a: assert property (@(posedge clk) disable iff (!chk_on_q)
    (p.uoa_sel && !rx_uoa_bit) |=> !st_act_enable)
    else $error("s/t activation enabled with uoa 0");

  g3_force_a: assert property (@(posedge clk) disable iff (!chk_on_q)
    !p.st_only_activation_n |=> force_g3)
    else $error("g3 not forced");

  ntm_bit_a: assert property (@(posedge clk) disable iff (!chk_on_q)
    (local_test && u_synced) |=> (!tx_ntm_bit && test_indicator))
    else $error("local test not signalled");

  metallic_reset_a: assert property (@(posedge clk) disable iff (!chk_on_q)
    (!p.metallic_test_en) |=> !force_h1)
    else $error("full reset honoured while disabled");

  ps_fixed_a: assert property (@(posedge clk) disable iff (!chk_on_q)
    local_test |=> (tx_ps1 && !tx_ps2))
    else $error("power status not fixed in local test");

  ps_map_a: assert property (@(posedge clk) disable iff (!chk_on_q)
    psd_eff |=> (tx_ps1 == $past(p.power_status_a) && tx_ps2 == $past(p.power_status_b)))
    else $error("power status not mapped");

  unable_echo_a: assert property (@(posedge clk) disable iff (!chk_on_q)
    s_loopc_held |=> (eoc_unable && st_info != NTLC_ST_INFO0))
    else $error("eoc loop 2 not refused");

  timing_sel_a: assert property (@(posedge clk) disable iff (!chk_on_q)
    $fell(p.fixed_timing_n) |=> !adaptive_timing)
    else $error("fixed timing not selected");

  relay_ctl_a: assert property (@(posedge clk) disable iff (!chk_on_q)
    (ext_mode && !rx_uoa_bit) |=> !loop2_relay_ctl)
    else $error("relay driven with uoa 0");

  info0_loop2_a: assert property (@(posedge clk) disable iff (!chk_on_q)
    (lt_loop2 && nontransp) ##1 (lt_loop2 && nontransp) |-> st_info == NTLC_ST_INFO0)
    else $error("info0 not sent in nontransparent loop 2");

  info4_code_a: assert property (@(posedge clk) disable iff (!chk_on_q)
    (local_test && p.test_sel == TSEL_INFO4) |=> st_info == NTLC_ST_INFO4)
    else $error("info4 test code not honoured");

  loopc_idle_a: assert property (@(posedge clk) disable iff (!chk_on_q)
    (frame_en && loopc_b1 && nontransp) |=> u_tx.b1 == IDLE_BYTE)
    else $error("looped b1 not idle toward u");

  b2_loopc_a: assert property (@(posedge clk) disable iff (!chk_on_q)
    (frame_en && man_b2 && !full_loop2) |=> st_tx.b2 == $past(st_rx.b2))
    else $error("b2 loop c not returned to s/t");

endmodule

// File: src/ntlc_sync.sv
// three-stage pin synchroniser with second/third agreement
`timescale 1ns/100ps
module ntlc_sync
  import ntlc_pkg::*;
#(
  parameter int unsigned W = 1
)(
  input  wire logic         clk,   // system clock
  input  wire logic         rstn,  // async reset, active low
  input  wire logic [W-1:0] din,   // asynchronous pin levels
  output logic      [W-1:0] dout   // filtered synchronous levels
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ----------------------------------------------------------------
  // shift chain; stage one is read only by stage two
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ----------------------------------------------------------------
  // accept a change only when stages two and three agree
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          dout[i] <= 1'b0;
        else if (s2_q[i] == s3_q[i])
          dout[i] <= s3_q[i];
      end
    end
  endgenerate

endmodule
